/* File: port_cfg_regs.sv */
// Top of the six-pin port configuration block: Wishbone register file plus pad decode.
// Assumes a classic Wishbone master with 32-bit data and word-aligned byte addresses.
`timescale 1ns/10ps
`default_nettype none
module port_cfg_regs
    import port_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [port_cfg_pkg::ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_wb_err,
    output logic [5:0] o_output_enable,
    output logic [5:0] o_schmitt_enable,
    output logic [5:0] o_drive_high_en,
    output logic [5:0] o_pull_up_en,
    output logic [5:0] o_pull_down_en,
    output logic [11:0] o_func_sel,
    output logic [17:0] o_drive_mode
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] direction;
        logic [5:0] schmitt;
        logic [5:0] open_drain;
        logic [5:0] pull_select;
        logic [5:0] pull_enable;
        logic [5:0] func_low;
        logic [5:0] func_high;
        logic [17:0] drive_code;
        logic [31:0] rdata;
        logic err;
    } regs_t;

    regs_t r;
    regs_t next_r;
    logic take;
    logic ack;
    logic hit;
    logic [31:0] rd_word;
    logic start;

    port_cfg_if cfg_bus ();

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    port_wb_slave u_slave (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_req(i_wb_cyc & i_wb_stb),
        .o_take(take),
        .o_ack(ack)
    );

    // A request is taken only while the slave idles, never during its own ack cycle
    assign start = i_wb_cyc & i_wb_stb & ~ack;

    // Pack the six drive codes into their word with reserved gaps at zero
    function automatic logic [31:0] pack_drive(input logic [17:0] codes);
        logic [31:0] w;
        w = 32'h00000000;
        for (int i = 0; i < NUM_PINS; i++) begin
            w[DRIVE_STRIDE*i +: DRIVE_W] = codes[DRIVE_W*i +: DRIVE_W]; // R8
        end
        return w;
    endfunction : pack_drive

    // Inverse of pack_drive; reserved bits are simply dropped
    function automatic logic [17:0] unpack_drive(input logic [31:0] w);
        logic [17:0] c;
        c = 18'h00000;
        for (int i = 0; i < NUM_PINS; i++) begin
            c[DRIVE_W*i +: DRIVE_W] = w[DRIVE_STRIDE*i +: DRIVE_W]; // R8
        end
        return c;
    endfunction : unpack_drive

    // ------------------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------------------
    // Only whole words are decoded; low address bits must be zero to hit
    always_comb begin
        hit = 1'b1;
        rd_word = 32'h00000000; // R10
        case (i_wb_adr) // R11
            OFS_PIN_DIRECTION: begin
                rd_word[DIR_POS +: NUM_PINS] = r.direction;
                rd_word[SCHMITT_POS +: NUM_PINS] = r.schmitt;
            end
            OFS_OPEN_DRAIN: rd_word[5:0] = r.open_drain;
            OFS_PULL_SELECT: rd_word[5:0] = r.pull_select;
            OFS_PULL_ENABLE: rd_word[5:0] = r.pull_enable;
            OFS_FUNC_LOW: rd_word[5:0] = r.func_low;
            OFS_FUNC_HIGH: rd_word[5:0] = r.func_high;
            OFS_DRIVER_CTRL: rd_word = pack_drive(r.drive_code);
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------------------
    // A write needs all four byte lanes; partial writes are answered but ignored,
    // which keeps sub-word stores from leaving a field half written
    always_comb begin
        next_r = r;
        // Read data and refusal latch at the taking edge, so they stand beside ack in the next cycle
        if (start) begin
            next_r.rdata = rd_word; // R12
            next_r.err = ~hit; // R11
        end else begin
            next_r.rdata = 32'h00000000;
            next_r.err = 1'b0;
        end
        // The write lands at the edge where the master samples ack
        if (take) begin
            if (i_wb_we && hit && (i_wb_sel == 4'hf)) begin // R11
                case (i_wb_adr)
                    OFS_PIN_DIRECTION: begin
                        next_r.direction = i_wb_dat[DIR_POS +: NUM_PINS]; // R1
                        next_r.schmitt = i_wb_dat[SCHMITT_POS +: NUM_PINS]; // R2
                    end
                    OFS_OPEN_DRAIN: next_r.open_drain = i_wb_dat[5:0]; // R3
                    OFS_PULL_SELECT: next_r.pull_select = i_wb_dat[5:0]; // R4
                    OFS_PULL_ENABLE: next_r.pull_enable = i_wb_dat[5:0]; // R5
                    OFS_FUNC_LOW: next_r.func_low = i_wb_dat[5:0]; // R6
                    OFS_FUNC_HIGH: next_r.func_high = i_wb_dat[5:0]; // R6
                    OFS_DRIVER_CTRL: next_r.drive_code = unpack_drive(i_wb_dat); // R8 R10
                    default: next_r.err = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '{direction: RST_DIRECTION, schmitt: RST_SCHMITT, open_drain: RST_OPEN_DRAIN,
                   pull_select: RST_PULL_SELECT, pull_enable: RST_PULL_ENABLE, func_low: RST_FUNC_LOW,
                   func_high: RST_FUNC_HIGH, drive_code: {NUM_PINS{RST_DRIVE_CODE}},
                   rdata: 32'h00000000, err: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // Read data and error are taken from the same edge that raises ack
    assign o_wb_dat = r.rdata;
    assign o_wb_ack = ack & ~r.err;
    assign o_wb_err = ack & r.err;

    // ------------------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------------------
    assign cfg_bus.direction = r.direction;
    assign cfg_bus.schmitt = r.schmitt;
    assign cfg_bus.open_drain = r.open_drain;
    assign cfg_bus.pull_select = r.pull_select;
    assign cfg_bus.pull_enable = r.pull_enable;
    assign cfg_bus.func_low = r.func_low;
    assign cfg_bus.func_high = r.func_high;
    assign cfg_bus.drive_code = r.drive_code;

    port_pad_decode u_decode (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .cfg(cfg_bus),
        .o_output_enable(o_output_enable),
        .o_schmitt_enable(o_schmitt_enable),
        .o_drive_high_en(o_drive_high_en),
        .o_pull_up_en(o_pull_up_en),
        .o_pull_down_en(o_pull_down_en),
        .o_func_sel(o_func_sel),
        .o_drive_mode(o_drive_mode)
    );
endmodule : port_cfg_regs
`default_nettype wire

/* File: port_cfg_pkg.sv */
// Constants, register map and field layout of the six-pin port configuration block.
// Assumes a single clock domain and a classic Wishbone slave in front of the registers.
// ----------------------------------------------------------------------------
// What this block does
// R1: Bits 5:0 of the direction register set each pin to input (0, reset) or output (1).
// R2: Bits 21:16 of the direction register enable each pin's input Schmitt trigger, effective only in output mode.
// R3: An open-drain bit per pin makes the output drive low only when set, and both levels when clear (reset).
// R4: A pull-select bit per pin picks the pull-down when clear and the pull-up when set.
// R5: A pull-enable bit per pin switches the selected pull device off when clear and on when set (default).
// R6: The two function-select bits of a pin choose GPIO, alternate one, two or three.
// R7: On pins 2 to 5 the drive code gives strong sharp, medium or soft edges for 000 to 010, weak for 011 and 111,
//     and medium for 100 to 110.
// R8: The output driver control register holds the six three-bit drive codes at bits 22:20 down to 2:0.
// R9: On pins 0 and 1 the drive code gives medium for 000 and 100 to 110, weak for 011 and 111, and 001, 010 unused.
// R10: Reserved bits read as zero and software should write zero to them.
// R11: All registers are decoded as whole 32-bit words.
// R12: Settings reach the pad controls on the edge after the write, with no other side effect.
// ----------------------------------------------------------------------------
package port_cfg_pkg;
    localparam int NUM_PINS = 6;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_PIN_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_OPEN_DRAIN = 8'h08;
    localparam logic [7:0] OFS_PULL_SELECT = 8'h0c;
    localparam logic [7:0] OFS_PULL_ENABLE = 8'h10;
    localparam logic [7:0] OFS_FUNC_LOW = 8'h14;
    localparam logic [7:0] OFS_FUNC_HIGH = 8'h18;
    localparam logic [7:0] OFS_DRIVER_CTRL = 8'he8;

    // Field positions
    localparam int DIR_POS = 0;
    localparam int SCHMITT_POS = 16;
    localparam int DRIVE_STRIDE = 4;
    localparam int DRIVE_W = 3;

    // Reset values
    localparam logic [5:0] RST_DIRECTION = 6'h00;
    localparam logic [5:0] RST_SCHMITT = 6'h00;
    localparam logic [5:0] RST_OPEN_DRAIN = 6'h00;
    localparam logic [5:0] RST_PULL_SELECT = 6'h3b;
    localparam logic [5:0] RST_PULL_ENABLE = 6'h3f;
    localparam logic [5:0] RST_FUNC_LOW = 6'h00;
    localparam logic [5:0] RST_FUNC_HIGH = 6'h00;
    localparam logic [2:0] RST_DRIVE_CODE = 3'h0;

    // Pin function selection
    typedef enum logic [1:0] {
        FUNC_GPIO = 2'b00,
        FUNC_ALT1 = 2'b01,
        FUNC_ALT2 = 2'b10,
        FUNC_ALT3 = 2'b11
    } pin_func_t;

    // Decoded drive strength
    typedef enum logic [2:0] {
        DRV_STRONG_SHARP = 3'b000,
        DRV_STRONG_MEDIUM = 3'b001,
        DRV_STRONG_SOFT = 3'b010,
        DRV_MEDIUM = 3'b011,
        DRV_WEAK = 3'b100,
        DRV_UNUSED = 3'b101
    } drive_mode_t;

    // Bus slave states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_t;
endpackage : port_cfg_pkg

/* File: port_cfg_if.sv */
// Configuration bundle passed from the register file to the pad decoder.
// Assumes both ends run on the same clock; signals are plain levels.
`timescale 1ns/10ps
`default_nettype none
interface port_cfg_if;
    logic [5:0] direction;
    logic [5:0] schmitt;
    logic [5:0] open_drain;
    logic [5:0] pull_select;
    logic [5:0] pull_enable;
    logic [5:0] func_low;
    logic [5:0] func_high;
    logic [17:0] drive_code;

    modport source (
        output direction, schmitt, open_drain, pull_select, pull_enable, func_low, func_high, drive_code
    );
    modport sink (
        input direction, schmitt, open_drain, pull_select, pull_enable, func_low, func_high, drive_code
    );
endinterface : port_cfg_if
`default_nettype wire

/* File: port_pad_decode.sv */
// Turns stored configuration into registered per-pin pad controls.
// Assumes configuration arrives over the sink modport in the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module port_pad_decode
    import port_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    port_cfg_if.sink cfg,
    output logic [5:0] o_output_enable,
    output logic [5:0] o_schmitt_enable,
    output logic [5:0] o_drive_high_en,
    output logic [5:0] o_pull_up_en,
    output logic [5:0] o_pull_down_en,
    output logic [11:0] o_func_sel,
    output logic [17:0] o_drive_mode
);
    // ------------------------------------------------------------------------
    // Drive code decode
    // ------------------------------------------------------------------------
    // Pins 0 and 1 lack the strong driver, so their table differs
    function automatic drive_mode_t decode_drive(input logic [2:0] code, input logic small_pin);
        drive_mode_t m;
        m = DRV_MEDIUM;
        case (code)
            3'h0: m = small_pin ? DRV_MEDIUM : DRV_STRONG_SHARP; // R7 R9
            3'h1: m = small_pin ? DRV_UNUSED : DRV_STRONG_MEDIUM; // R7 R9
            3'h2: m = small_pin ? DRV_UNUSED : DRV_STRONG_SOFT; // R7 R9
            3'h3, 3'h7: m = DRV_WEAK; // R7 R9
            default: m = DRV_MEDIUM; // R7 R9
        endcase
        return m;
    endfunction : decode_drive

    typedef struct packed {
        logic [5:0] oe;
        logic [5:0] st;
        logic [5:0] hi;
        logic [5:0] pu;
        logic [5:0] pd;
        logic [11:0] fs;
        logic [17:0] dm;
    } pad_state_t;

    pad_state_t st;
    pad_state_t next_st;

    // ------------------------------------------------------------------------
    // Combinational pad control
    // ------------------------------------------------------------------------
    // Schmitt enable is gated by direction since it only matters for outputs
    always_comb begin
        next_st = st;
        for (int i = 0; i < NUM_PINS; i++) begin
            next_st.oe[i] = cfg.direction[i]; // R1
            next_st.st[i] = cfg.schmitt[i] & cfg.direction[i]; // R2
            next_st.hi[i] = cfg.direction[i] & ~cfg.open_drain[i]; // R3
            next_st.pu[i] = cfg.pull_enable[i] & cfg.pull_select[i]; // R4 R5
            next_st.pd[i] = cfg.pull_enable[i] & ~cfg.pull_select[i]; // R4 R5
            next_st.fs[2*i +: 2] = {cfg.func_high[i], cfg.func_low[i]}; // R6
            next_st.dm[3*i +: 3] = decode_drive(cfg.drive_code[3*i +: 3], i < 2);
        end
    end

    // Registered outputs keep pad controls glitch free
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '{oe: 6'h00, st: 6'h00, hi: 6'h00, pu: RST_PULL_ENABLE & RST_PULL_SELECT,
                    pd: RST_PULL_ENABLE & ~RST_PULL_SELECT, fs: 12'h000, dm: 18'h00000};
        end else begin
            st <= next_st; // R12
        end
    end

    assign o_output_enable = st.oe;
    assign o_schmitt_enable = st.st;
    assign o_drive_high_en = st.hi;
    assign o_pull_up_en = st.pu;
    assign o_pull_down_en = st.pd;
    assign o_func_sel = st.fs;
    assign o_drive_mode = st.dm;
endmodule : port_pad_decode
`default_nettype wire

/* File: port_wb_slave.sv */
// Classic Wishbone handshake: one ack cycle after each strobed request.
// Assumes a master that holds requests until ack and drops cyc between transfers.
`timescale 1ns/10ps
`default_nettype none
module port_wb_slave
    import port_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_req,
    output logic o_take,
    output logic o_ack
);
    typedef struct packed {
        bus_state_t state;
    } wb_state_t;

    wb_state_t s;
    wb_state_t next_s;

    // ------------------------------------------------------------------------
    // Ack sequencing
    // ------------------------------------------------------------------------
    // Ack drops for one cycle after each transfer so a held request is not taken twice
    always_comb begin
        next_s = s;
        case (s.state)
            BUS_IDLE: begin
                if (i_req) begin
                    next_s.state = BUS_ACK;
                end
            end
            BUS_ACK: begin
                next_s.state = BUS_IDLE;
            end
            default: begin
                next_s.state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            s <= '{state: BUS_IDLE};
        end else begin
            s <= next_s;
        end
    end

    assign o_ack = (s.state == BUS_ACK);
    assign o_take = (s.state == BUS_ACK) & i_req;
endmodule : port_wb_slave
`default_nettype wire

/* File: port_cfg_regs_chk.sv */
// Concurrent checks on the top-level ports of the port configuration block.
// Assumes a Wishbone master that drops cyc for a cycle between transfers.
`timescale 1ns/10ps
`default_nettype none
module port_cfg_regs_chk
    import port_cfg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [port_cfg_pkg::ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_wb_err,
    input wire logic [5:0] o_output_enable,
    input wire logic [5:0] o_schmitt_enable,
    input wire logic [5:0] o_drive_high_en,
    input wire logic [5:0] o_pull_up_en,
    input wire logic [5:0] o_pull_down_en,
    input wire logic [11:0] o_func_sel,
    input wire logic [17:0] o_drive_mode
);
    // ------------------------------------------------------------------
    // Bus answers and pad relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    logic mapped;
    // Address decode seen from outside, word offsets only
    assign mapped = i_wb_adr inside {OFS_PIN_DIRECTION, OFS_OPEN_DRAIN, OFS_PULL_SELECT, OFS_PULL_ENABLE,
        OFS_FUNC_LOW, OFS_FUNC_HIGH, OFS_DRIVER_CTRL};
    AST_ANSWER_NEXT: assert property ($rose(i_wb_cyc && i_wb_stb) |=> (o_wb_ack || o_wb_err))
        else $error("no answer one cycle after request");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_ONE_ANSWER: assert property (!(o_wb_ack && o_wb_err))
        else $error("ack and err together");
    AST_ERR_UNMAPPED: assert property ($rose(i_wb_cyc && i_wb_stb) && !mapped |=> o_wb_err)
        else $error("unmapped address not refused");
    AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data outside ack");
    AST_RSVD_DRV: assert property (o_wb_ack && i_wb_adr == OFS_DRIVER_CTRL
        |-> (o_wb_dat & 32'hff888888) == 32'h0) else $error("reserved driver bits read nonzero");
    AST_DIR_APPLY: assert property (o_wb_ack && i_wb_we && i_wb_adr == OFS_PIN_DIRECTION && i_wb_sel == 4'hf
        |-> ##2 o_output_enable == $past(i_wb_dat[5:0], 2)) else $error("direction not applied");
    AST_SCHMITT_OUT: assert property ((o_schmitt_enable & ~o_output_enable) == 6'h0)
        else $error("schmitt on an input pin");
    AST_OD_HIGH: assert property ((o_drive_high_en & ~o_output_enable) == 6'h0)
        else $error("high drive on an input pin");
    AST_PULL_EXCL: assert property ((o_pull_up_en & o_pull_down_en) == 6'h0)
        else $error("both pulls on");
endmodule : port_cfg_regs_chk
`default_nettype wire

/* File: tb_port_cfg_regs.sv */
// Self-checking bench for the port configuration block over classic Wishbone.
// Assumes the one-cycle ack and the pad update one edge after the write.
`timescale 1ns/10ps
`default_nettype none
module tb_port_cfg_regs;
    import port_cfg_pkg::*;
    logic mclk = 1'b0;
    logic resetn, cyc, stb, we, ack, err;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [5:0] oe, st, dh, pu, pd;
    logic [11:0] fs;
    logic [17:0] dm;
    int err_total = 0;
    int check_count = 0;
    // ------------------------------------------------------------------
    // Clock, design and helpers
    // ------------------------------------------------------------------
    always #12.5 mclk = ~mclk;
    port_cfg_regs u_port_cfg_regs(.i_mclk(mclk), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
        .o_output_enable(oe), .o_schmitt_enable(st), .o_drive_high_en(dh), .o_pull_up_en(pu),
        .o_pull_down_en(pd), .o_func_sel(fs), .o_drive_mode(dm));
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic results;
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    // One classic cycle; request held until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge mclk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 16);
        q = rdat;
        e = err;
        {cyc, stb, we} <= 3'b000;
        if (n >= 16) begin
            err_total++;
            results();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, 4'hf, q, e);
        chk("write err", {31'h0, e}, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, 4'hf, q, e);
        chk($sformatf("reg %h", a), q, exp);
    endtask : rd
    // Pads follow one edge after the register
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle
    task automatic do_reset;
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
    endtask : do_reset
    function automatic logic [2:0] mode_of(input int pin, input logic [2:0] c);
        if (c == 3'h3 || c == 3'h7) begin
            return DRV_WEAK;
        end
        if (pin >= 2 && c <= 3'h2) begin
            return c;
        end
        return (c == 3'h1 || c == 3'h2) ? DRV_UNUSED : DRV_MEDIUM;
    endfunction : mode_of
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] ofs[7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'he8};
        logic [31:0] rv[7] = '{32'h0, 32'h0, 32'h3b, 32'h3f, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            rd(ofs[i], rv[i]);
        end
        chk("pads", {oe, st, dh, fs}, 32'h0);
        chk("pulls", {pu, pd}, {6'h3b, 6'h04});
        chk("drive", dm, 18'h0001b);
    endtask : t_reset
    task automatic t_dir;
        wr(8'h04, 32'hffffff15);
        rd(8'h04, 32'h003f0015);
        settle();
        chk("dir pads", {oe, st, dh}, {6'h15, 6'h15, 6'h15});
    endtask : t_dir
    task automatic t_od;
        wr(8'h04, 32'h3f);
        wr(8'h08, 32'hffffff2a);
        rd(8'h08, 32'h2a);
        settle();
        chk("od pads", {oe, st, dh}, {6'h3f, 6'h00, 6'h15});
    endtask : t_od
    task automatic t_pull;
        logic [31:0] q;
        logic e;
        wr(8'h0c, 32'h0f);
        wr(8'h10, 32'h33);
        bus(1'b1, 8'h10, 32'h0, 4'h3, q, e);
        rd(8'h10, 32'h33);
        settle();
        chk("pulls", {pu, pd}, {6'h03, 6'h30});
    endtask : t_pull
    task automatic t_func;
        wr(8'h14, 32'h05);
        wr(8'h18, 32'h06);
        settle();
        chk("func", fs, 12'h039);
    endtask : t_func
    task automatic t_drive;
        logic [31:0] d;
        logic [17:0] exp;
        for (int c = 0; c < 8; c++) begin
            d = 32'h0;
            for (int p = 0; p < 6; p++) begin
                d[4*p+:3] = 3'((c + p) % 8);
                exp[3*p+:3] = mode_of(p, 3'((c + p) % 8));
            end
            wr(8'he8, d | 32'hff888888);
            rd(8'he8, d);
            settle();
            chk("drive", dm, exp);
        end
    endtask : t_drive
    task automatic t_err;
        logic [31:0] q;
        logic e;
        bus(1'b0, 8'h00, 32'h0, 4'hf, q, e);
        chk("unmapped read", q, 32'h0);
        chk("unmapped read err", {31'h0, e}, 32'h1);
        bus(1'b1, 8'hec, 32'hffffffff, 4'hf, q, e);
        chk("unmapped write", {31'h0, e}, 32'h1);
        rd(8'he8, 32'h00432107);
    endtask : t_err
    initial begin
        {resetn, cyc, stb, we, adr, sel, wdat} = '0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_dir();
        t_od();
        t_pull();
        t_func();
        t_drive();
        t_err();
        do_reset();
        t_reset();
        results();
    end
endmodule : tb_port_cfg_regs
bind port_cfg_regs port_cfg_regs_chk u_port_cfg_regs_chk(.i_mclk(i_mclk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_err(o_wb_err), .o_output_enable(o_output_enable),
    .o_schmitt_enable(o_schmitt_enable), .o_drive_high_en(o_drive_high_en), .o_pull_up_en(o_pull_up_en),
    .o_pull_down_en(o_pull_down_en), .o_func_sel(o_func_sel), .o_drive_mode(o_drive_mode));
`default_nettype wire
